// File: rtl/sdd_pkg.sv
package sdd_pkg;

  // clock and link rates
  localparam longint SYS_CLK_HZ   = 64'd50000000;
  localparam longint MASTER_HZ    = 64'd16384000;
  localparam int     MOD_DIV      = 16;
  localparam longint MOD_RATE_HZ  = MASTER_HZ / MOD_DIV;
  localparam int     NCO_W        = 32;
  // twice the bit rate: one toggle per half period of the sync clock
  localparam logic [NCO_W-1:0] NCO_STEP =
    NCO_W'(((MOD_RATE_HZ * 64'd2) << NCO_W) / SYS_CLK_HZ);

  // channel layout
  localparam int N_DEV       = 4;
  localparam int MOD_PER_DEV = 3;
  localparam int N_CHAN      = N_DEV * MOD_PER_DEV;
  localparam int CHAN_W      = 4;

  // decimation filter
  localparam int DEC_RATIO   = 128;
  localparam int DEC_W       = 7;
  localparam logic [DEC_W-1:0] DEC_LAST = 7'h7F;
  localparam int ACC_W       = 24;
  localparam int OUT_SHIFT   = 2;
  localparam int SAMPLE_W    = 24;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 24'h7FFFFF;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = 24'h800000;

  // output buffer
  localparam int FIFO_DEPTH  = 16;
  localparam int FIFO_WIDTH  = CHAN_W + SAMPLE_W;

  // reset values
  localparam logic [NCO_W-1:0]  NCO_RST  = 32'h00000000;
  localparam logic [DEC_W-1:0]  DEC_RST  = 7'h00;
  localparam logic [ACC_W-1:0]  ACC_RST  = 24'h000000;
  localparam logic [CHAN_W-1:0] CHAN_RST = 4'h0;

endpackage

// File: rtl/sdd_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sdd_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_idx_reg;
  logic [AW-1:0]    rd_idx_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // full and empty come straight from the occupancy count
  assign o_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_valid = (count_reg != '0);
  assign o_data  = mem_reg[rd_idx_reg];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  // storage, no reset needed on data
  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem_reg[wr_idx_reg] <= i_data;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_idx_reg <= '0;
      rd_idx_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_idx_reg <= (wr_idx_reg == AW'(DEPTH-1)) ? '0 : wr_idx_reg + 1'b1;
      end
      if (pop)
      begin
        rd_idx_reg <= (rd_idx_reg == AW'(DEPTH-1)) ? '0 : rd_idx_reg + 1'b1;
      end
      case ({push, pop})
        2'b10:   count_reg <= count_reg + 1'b1;
        2'b01:   count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: rtl/sdd_decimator.sv
`timescale 1ns/1ps
`default_nettype none

module sdd_decimator (
  input  wire logic                                i_sys_clk,
  input  wire logic                                i_rst,
  input  wire logic [sdd_pkg::N_CHAN-1:0]          i_mod_data,
  output logic                                     o_sync_clk,
  output logic                                     o_sample_valid,
  output logic [sdd_pkg::CHAN_W-1:0]               o_sample_chan,
  output logic signed [sdd_pkg::SAMPLE_W-1:0]      o_sample_data,
  input  wire logic                                i_sample_ready,
  output logic                                     o_overrun
);

  localparam int NC  = sdd_pkg::N_CHAN;
  localparam int AW  = sdd_pkg::ACC_W;
  localparam int SW  = sdd_pkg::SAMPLE_W;
  localparam int CW  = sdd_pkg::CHAN_W;
  localparam int FW  = sdd_pkg::FIFO_WIDTH;
  localparam int XW  = AW + sdd_pkg::OUT_SHIFT;

  // clamp a widened filter result into the signed output range
  function automatic logic signed [SW-1:0] clamp_sample(input logic signed [XW-1:0] v);
    logic signed [XW-1:0] hi;
    logic signed [XW-1:0] lo;
    hi = XW'(sdd_pkg::SAMPLE_MAX);
    lo = {{(XW-SW){1'b1}}, sdd_pkg::SAMPLE_MIN};
    if (v > hi)
    begin
      clamp_sample = sdd_pkg::SAMPLE_MAX;
    end
    else if (v < lo)
    begin
      clamp_sample = sdd_pkg::SAMPLE_MIN;
    end
    else
    begin
      clamp_sample = v[SW-1:0];
    end
  endfunction

  logic [sdd_pkg::NCO_W-1:0] nco_reg;
  logic                      nco_carry;
  logic [sdd_pkg::NCO_W-1:0] nco_next;
  logic                      fall_d1_reg;
  logic                      fall_d2_reg;
  logic [NC-1:0]             data_s1_reg;
  logic [NC-1:0]             data_s2_reg;
  logic [sdd_pkg::DEC_W-1:0] dec_cnt_reg;
  logic                      bit_tick;
  logic                      frame_end;
  logic signed [SW-1:0]      hold_reg [NC];
  logic                      push_busy_reg;
  logic [CW-1:0]             push_idx_reg;
  logic                      fifo_in_ready;
  logic                      fifo_out_valid;
  logic [FW-1:0]             fifo_out_data;
  logic                      fifo_pop;

  // phase accumulator at twice the bit rate; the 50 MHz clock is not a
  // whole multiple, so the sync period jitters by one system cycle
  assign {nco_carry, nco_next} = {1'b0, nco_reg} + {1'b0, sdd_pkg::NCO_STEP};

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      nco_reg    <= sdd_pkg::NCO_RST;
      o_sync_clk <= 1'b0;
    end
    else
    begin
      nco_reg <= nco_next;
      if (nco_carry)
      begin
        o_sync_clk <= ~o_sync_clk;
      end
    end
  end

  // front-ends change data after the rising sync edge, so the host takes
  // each bit at the falling edge, delayed to match the input synchroniser
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      fall_d1_reg <= 1'b0;
      fall_d2_reg <= 1'b0;
    end
    else
    begin
      fall_d1_reg <= nco_carry && o_sync_clk;
      fall_d2_reg <= fall_d1_reg;
    end
  end

  assign bit_tick = fall_d2_reg;

  // two-stage synchroniser; the lines come through isolators or direct
  // wiring, both asynchronous to this clock
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      data_s1_reg <= '0;
      data_s2_reg <= '0;
    end
    else
    begin
      data_s1_reg <= i_mod_data;
      data_s2_reg <= data_s1_reg;
    end
  end

  // one output word per 128 modulator bits
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dec_cnt_reg <= sdd_pkg::DEC_RST;
    end
    else if (bit_tick)
    begin
      dec_cnt_reg <= dec_cnt_reg + 1'b1;
    end
  end

  assign frame_end = bit_tick && (dec_cnt_reg == sdd_pkg::DEC_LAST);

  // identical third-order sinc filter per channel, neutral included
  genvar ch;
  generate
    for (ch = 0; ch < NC; ch++)
    begin : g_chan
      logic signed [AW-1:0] int1_reg;
      logic signed [AW-1:0] int2_reg;
      logic signed [AW-1:0] int3_reg;
      logic signed [AW-1:0] dly1_reg;
      logic signed [AW-1:0] dly2_reg;
      logic signed [AW-1:0] dly3_reg;
      logic signed [AW-1:0] in_val;
      logic signed [AW-1:0] int1_next;
      logic signed [AW-1:0] int2_next;
      logic signed [AW-1:0] int3_next;
      logic signed [AW-1:0] comb1;
      logic signed [AW-1:0] comb2;
      logic signed [AW-1:0] comb3;
      logic signed [XW-1:0] scaled;

      // a one counts +1 and a zero -1, so a stuck-high line is simply
      // full positive scale and needs no special case
      assign in_val    = data_s2_reg[ch] ? AW'(1) : -AW'(1);
      assign int1_next = int1_reg + in_val;
      assign int2_next = int2_reg + int1_next;
      assign int3_next = int3_reg + int2_next;
      // modular arithmetic: wraps in the integrators cancel in the combs
      assign comb1     = int3_next - dly1_reg;
      assign comb2     = comb1 - dly2_reg;
      assign comb3     = comb2 - dly3_reg;
      // filter gain is 2^21; shifting by two maps full bit density to
      // 2^23, so nominal input lands near 5.3 million codes
      assign scaled    = XW'(comb3) <<< sdd_pkg::OUT_SHIFT;

      // integrators run every bit; combs and output only at frame end
      always_ff @(posedge i_sys_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          int1_reg      <= sdd_pkg::ACC_RST;
          int2_reg      <= sdd_pkg::ACC_RST;
          int3_reg      <= sdd_pkg::ACC_RST;
          dly1_reg      <= sdd_pkg::ACC_RST;
          dly2_reg      <= sdd_pkg::ACC_RST;
          dly3_reg      <= sdd_pkg::ACC_RST;
          hold_reg[ch]  <= sdd_pkg::ACC_RST;
        end
        else if (bit_tick)
        begin
          int1_reg <= int1_next;
          int2_reg <= int2_next;
          int3_reg <= int3_next;
          if (frame_end)
          begin
            dly1_reg     <= int3_next;
            dly2_reg     <= comb1;
            dly3_reg     <= comb2;
            // overrange input saturates rather than folding over
            hold_reg[ch] <= clamp_sample(scaled);
          end
        end
      end
    end
  endgenerate

  // after each frame the twelve words are pushed into the buffer in
  // channel order; the buffer stalls this when the reader falls behind
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      push_busy_reg <= 1'b0;
      push_idx_reg  <= sdd_pkg::CHAN_RST;
    end
    else if (frame_end)
    begin
      push_busy_reg <= 1'b1;
      push_idx_reg  <= sdd_pkg::CHAN_RST;
    end
    else if (push_busy_reg && fifo_in_ready)
    begin
      push_idx_reg <= push_idx_reg + 1'b1;
      if (push_idx_reg == CW'(NC-1))
      begin
        push_busy_reg <= 1'b0;
      end
    end
  end

  // sticky: a new frame arrived before the last one was fully pushed,
  // so the oldest unpushed words were replaced; cleared only by reset
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_overrun <= 1'b0;
    end
    else if (frame_end && push_busy_reg)
    begin
      o_overrun <= 1'b1;
    end
  end

  sdd_fifo #(
    .WIDTH (FW),
    .DEPTH (sdd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_valid   (push_busy_reg),
    .o_ready   (fifo_in_ready),
    .i_data    ({push_idx_reg, hold_reg[push_idx_reg]}),
    .o_valid   (fifo_out_valid),
    .i_ready   (fifo_pop),
    .o_data    (fifo_out_data)
  );

  // output register stage so every port comes from a flop
  assign fifo_pop = fifo_out_valid && (!o_sample_valid || i_sample_ready);

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sample_valid <= 1'b0;
      o_sample_chan  <= sdd_pkg::CHAN_RST;
      o_sample_data  <= sdd_pkg::ACC_RST;
    end
    else if (fifo_pop)
    begin
      o_sample_valid <= 1'b1;
      o_sample_chan  <= fifo_out_data[FW-1 -: CW];
      o_sample_data  <= fifo_out_data[SW-1:0];
    end
    else if (i_sample_ready)
    begin
      o_sample_valid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: test/sdd_decimator_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sdd_decimator_checker (
  input wire logic                                  i_sys_clk,
  input wire logic                                  i_rst,
  input wire logic [sdd_pkg::N_CHAN-1:0]            i_mod_data,
  input wire logic                                  o_sync_clk,
  input wire logic                                  o_sample_valid,
  input wire logic [sdd_pkg::CHAN_W-1:0]            o_sample_chan,
  input wire logic signed [sdd_pkg::SAMPLE_W-1:0]   o_sample_data,
  input wire logic                                  i_sample_ready,
  input wire logic                                  o_overrun
);
  logic        sync_q;
  logic        seen_h;
  logic        seen_f;
  logic [5:0]  half_cnt;
  logic [12:0] gap_cnt;
  wire logic   take = o_sample_valid && i_sample_ready;
  wire logic   tog  = o_sync_clk != sync_q;
  wire logic   first = take && o_sample_chan == 4'h0;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // interval counters; the first interval after reset has no start, so it is skipped
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync_q   <= 1'b0;
      seen_h   <= 1'b0;
      seen_f   <= 1'b0;
      half_cnt <= 6'h00;
      gap_cnt  <= 13'h0000;
    end
    else
    begin
      sync_q   <= o_sync_clk;
      seen_h   <= seen_h || tog;
      seen_f   <= seen_f || first;
      half_cnt <= tog ? 6'h01 : half_cnt + 6'h01;
      gap_cnt  <= first ? 13'h0001 : gap_cnt + 13'h0001;
    end
  end

  a_reset_quiet: assert property (disable iff (1'b0)
    i_rst |-> !o_sample_valid && !o_overrun && !o_sync_clk) else $error("busy in reset");
  a_sync_idle: assert property ($fell(i_rst) |-> !o_sync_clk [*8])
    else $error("sync clock starts early");
  a_half_period: assert property (tog && seen_h |-> half_cnt inside {[6'h18:6'h19]})
    else $error("sync half period wrong");
  a_hold_stall: assert property (o_sample_valid && !i_sample_ready |=>
    o_sample_valid && $stable(o_sample_chan) && $stable(o_sample_data)) else $error("word lost");
  a_chan_range: assert property (o_sample_valid |-> o_sample_chan <= 4'hB)
    else $error("channel out of range");
  a_chan_order: assert property (take && o_sample_chan != 4'hB && !o_overrun |=>
    !o_sample_valid || o_sample_chan == $past(o_sample_chan) + 4'h1) else $error("bad order");
  a_frame_burst: assert property (first && !o_overrun |-> ##[1:1000] (take && o_sample_chan == 4'hB))
    else $error("frame incomplete");
  a_frame_rate: assert property (first && seen_f && !o_overrun |->
    gap_cnt inside {[13'h1856:13'h187E]}) else $error("frame spacing wrong");
  a_overrun_hold: assert property (o_overrun |=> o_overrun)
    else $error("overrun flag dropped");

  c_stall: cover property (o_sample_valid && !i_sample_ready);
  c_overrun: cover property ($rose(o_overrun));
  c_clamp: cover property (take && o_sample_data == sdd_pkg::SAMPLE_MAX);
endmodule

bind sdd_decimator sdd_decimator_checker u_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_mod_data(i_mod_data), .o_sync_clk(o_sync_clk),
  .o_sample_valid(o_sample_valid), .o_sample_chan(o_sample_chan),
  .o_sample_data(o_sample_data), .i_sample_ready(i_sample_ready), .o_overrun(o_overrun));
`default_nettype wire

// File: test/sdd_frontend_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdd_frontend_model (
  input  wire logic        i_sync_clk,
  input  wire logic        i_rst,
  input  wire logic        i_tie_neutral,
  input  wire logic [47:0] i_density,
  output logic      [11:0] o_mod_data
);
  logic [2:0]  phase_reg;
  logic [11:0] bits_reg;

  // next bit launched just after the rising sync edge; the eight-bit pattern
  // keeps its ripple inside the filter notches, so results are exact
  always_ff @(posedge i_sync_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      phase_reg <= 3'h0;
      bits_reg  <= 12'h000;
    end
    else
    begin
      phase_reg <= phase_reg + 3'h1;
      for (int c = 0; c < 12; c++)
        bits_reg[c] <= {1'h0, phase_reg} < i_density[c*4 +: 4];
    end
  end

  // lines run straight to the host; an unmonitored neutral is strapped high
  assign o_mod_data = i_tie_neutral ? {3'h7, bits_reg[8:0]} : bits_reg;
endmodule
`default_nettype wire

// File: test/sdd_decimator_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdd_decimator_tb;
  logic               sys_clk = 1'b0;
  logic               rst = 1'b0;
  logic               ready = 1'b0;
  logic               stall = 1'b0;
  logic               tie_n = 1'b0;
  logic [47:0]        dens = 48'h0;
  logic [11:0]        mod_data;
  logic               sync;
  logic               valid;
  logic               ovr;
  logic [3:0]         chan;
  logic signed [23:0] data;
  logic [27:0]        exp_q[$];
  int                 err_total = 0;
  int                 tests_run = 0;
  int                 cycles = 0;
  int                 ends = 0;

  sdd_frontend_model u_fe (.i_sync_clk(sync), .i_rst(rst), .i_tie_neutral(tie_n),
    .i_density(dens), .o_mod_data(mod_data));
  sdd_decimator u_dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_mod_data(mod_data),
    .o_sync_clk(sync), .o_sample_valid(valid), .o_sample_chan(chan),
    .o_sample_data(data), .i_sample_ready(ready), .o_overrun(ovr));

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;

  // consumer takes about three words in four, or none while stalled
  always @(posedge sys_clk)
    ready <= !stall && ($urandom % 4 != 0);

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp_word(input logic [27:0] got, input logic [27:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // mean density (2k-8)/8 scaled to full 24-bit range; all ones clamps
  function automatic logic [23:0] exp_code(input int c);
    logic [3:0] k;
    k = (c > 8 && tie_n) ? 4'h8 : dens[c*4 +: 4];
    return (k == 4'h8) ? sdd_pkg::SAMPLE_MAX : ({20'h0, k} - 24'h4) << 21;
  endfunction

  // three settling frames, then one frame noted word by word
  task automatic check_frame();
    int base;
    base = ends;
    wait (ends == base + 3);
    @(negedge sys_clk);
    for (int c = 0; c < 12; c++)
      exp_q.push_back({4'(c), exp_code(c)});
    wait (exp_q.size() == 0);
    @(negedge sys_clk);
    cmp_flag(ovr, 1'b0);
  endtask

  // scoreboard: while notes wait, each accepted word is matched with the oldest note
  always @(posedge sys_clk)
  begin
    cycles++;
    if (valid === 1'b1 && ready === 1'b1)
    begin
      if (chan === 4'hB)
        ends++;
      if (exp_q.size() > 0)
        cmp_word({chan, data}, exp_q.pop_front());
    end
    if (cycles == 90000)
    begin
      err_total++;
      wrap_up();
    end
  end

  initial
  begin
    // a real rising edge at time zero, else the async resets never fire
    rst <= 1'b1;
    void'($urandom(32'hA5FED847));
    for (int c = 0; c < 12; c++)
      dens[c*4 +: 4] = 4'($urandom % 9);
    dens[7:0] = 8'h80;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    check_frame();
    @(posedge sys_clk);
    stall <= 1'b1;
    repeat (392) @(negedge sync);
    @(negedge sys_clk);
    cmp_flag(ovr, 1'b1);
    cmp_flag(valid, 1'b1);
    @(posedge sys_clk);
    stall <= 1'b0;
    for (int i = 0; i < 300 && valid !== 1'b0; i++)
      @(posedge sys_clk);
    @(negedge sys_clk);
    cmp_flag(valid, 1'b0);
    @(posedge sys_clk);
    rst <= 1'b1;
    tie_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp_flag(ovr | valid | sync, 1'b0);
    @(posedge sys_clk);
    rst <= 1'b0;
    check_frame();
    wrap_up();
  end
endmodule
`default_nettype wire
